// ===== tb/rmx_exec_asserts.sv
// Property checker for the return and move execution unit.
`timescale 1ns/1ps
module rmx_exec_asserts (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [1:0] QPHASE,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic HIGH_PRIO_MODE,
  input wire logic [rmx_pkg::PC_W-1:0] STACK_TOP,
  input wire rmx_pkg::rmx_ctx_t SHADOW,
  input wire logic STACK_POP,
  input wire logic PC_LOAD,
  input wire logic [rmx_pkg::PC_W-1:0] PC_VALUE,
  input wire logic LATCH_WRITE,
  input wire logic HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_SET,
  input wire logic LOW_PRIORITY_GLOBAL_IRQ_ENABLE_SET,
  input wire logic CTX_LOAD,
  input wire rmx_pkg::rmx_ctx_t CTX_OUT,
  input wire logic DEST_READ,
  input wire rmx_pkg::rmx_fwr_t DEST_WRITE,
  input wire logic BUSY
);
  import rmx_pkg::*;
  logic take;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // A request only counts when the unit is idle at the start of a cycle.
  assign take = INSTR_VALID && QPHASE == 2'h0 && !BUSY;
  AST_POP: assert property (take && INSTR[15:1] == 15'h0008 |=> STACK_POP && PC_LOAD && PC_VALUE == $past(STACK_TOP))
    else $error("interrupt return did not pop the stack");
  AST_IE: assert property (take && INSTR[15:1] == 15'h0008 |=> HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_SET == $past(HIGH_PRIO_MODE)
    && LOW_PRIORITY_GLOBAL_IRQ_ENABLE_SET == !$past(HIGH_PRIO_MODE)) else $error("wrong enable level set");
  AST_RESTORE: assert property (take && INSTR == 16'h0011 |=> CTX_LOAD && CTX_OUT == $past(SHADOW))
    else $error("shadow restore missing");
  AST_KEEP: assert property (take && INSTR == 16'h0010 |=> !CTX_LOAD[*2]) else $error("context changed");
  AST_LIT: assert property (take && INSTR[15:8] == 8'h0C |=> CTX_LOAD && CTX_OUT.acc == $past(INSTR[7:0])
    && PC_LOAD && PC_VALUE == $past(STACK_TOP)) else $error("literal return wrong");
  AST_LATCH: assert property (!LATCH_WRITE) else $error("latch written");
  AST_NO_DREAD: assert property (!DEST_READ) else $error("destination read");
  AST_MOVE_WR: assert property (DEST_WRITE.en |-> QPHASE == 2'h3 && $past(INSTR[15:12]) == 4'hF)
    else $error("move write outside last quarter");
  AST_RET_TWO: assert property (take && (INSTR[15:1] == 15'h0008 || INSTR[15:8] == 8'h0C) |=> BUSY[*7] ##1 !BUSY)
    else $error("return did not take two cycles");
  COV_RESTORE: cover property (take && INSTR == 16'h0011);
  COV_LIT: cover property (take && INSTR[15:8] == 8'h0C);
  COV_MOVE: cover property (DEST_WRITE.en);
endmodule : rmx_exec_asserts
bind rmx_exec rmx_exec_asserts chk_i (.*);

// ===== tb/tb.sv
// Self-checking bench for the return and move execution unit.
`timescale 1ns/1ps
module tb;
  import rmx_pkg::*;
  logic MCLK, RESETN, INSTR_VALID, HIGH_PRIO_MODE, STACK_POP, PC_LOAD, LATCH_WRITE, CTX_LOAD, SRC_READ;
  logic DEST_READ, PIPE_FLUSH, BUSY, HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_SET, LOW_PRIORITY_GLOBAL_IRQ_ENABLE_SET;
  logic [1:0] QPHASE = 2'h0;
  logic [15:0] INSTR;
  logic [PC_W-1:0] STACK_TOP, PC_VALUE;
  logic [DATA_W-1:0] SRC_DATA;
  logic [FADDR_W-1:0] SRC_ADDR;
  rmx_ctx_t SHADOW, CTX_IN, CTX_OUT;
  rmx_fwr_t DEST_WRITE;
  int n_fail = 0;
  int tests_run = 0;
  rmx_exec uut (.*);
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  always @(negedge MCLK) QPHASE <= QPHASE + 2'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Issues a word so that it is taken on the next quarter-zero edge.
  task automatic send(input logic [15:0] w);
    repeat (8) @(negedge MCLK);
    while (QPHASE !== 2'h3) @(negedge MCLK);
    INSTR <= w;
    INSTR_VALID <= 1'b1;
    @(negedge MCLK);
    INSTR_VALID <= 1'b0;
  endtask : send
  task automatic ret_irq(input logic s, input logic hp);
    HIGH_PRIO_MODE <= hp;
    send({15'h0008, s});
    chk({STACK_POP, PC_LOAD, PIPE_FLUSH, BUSY, PC_VALUE}, {4'hF, STACK_TOP});
    chk({HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_SET, LOW_PRIORITY_GLOBAL_IRQ_ENABLE_SET}, {hp, ~hp});
    chk({CTX_LOAD, CTX_OUT}, s ? {1'b1, SHADOW} : {1'b0, CTX_IN});
    @(negedge MCLK);
    chk({STACK_POP, PC_LOAD, BUSY}, 3'h1);
    repeat (5) @(negedge MCLK);
    chk(BUSY, 1'b1);
    @(negedge MCLK);
    chk(BUSY, 1'b0);
  endtask : ret_irq
  task automatic ret_lit;
    send(16'h0CA5);
    chk({CTX_LOAD, CTX_OUT.acc, PC_LOAD, PC_VALUE}, {1'b1, 8'hA5, 1'b1, STACK_TOP});
    chk(LATCH_WRITE, 1'b0);
    @(negedge MCLK);
    chk({CTX_LOAD, PC_LOAD, BUSY}, 3'h1);
    repeat (5) @(negedge MCLK);
    chk(BUSY, 1'b1);
    @(negedge MCLK);
    chk(BUSY, 1'b0);
  endtask : ret_lit
  task automatic move;
    send(16'hC123);
    chk({SRC_READ, SRC_ADDR, DEST_READ}, {1'b1, 12'h123, 1'b0});
    repeat (5) @(negedge MCLK);
    INSTR <= 16'hF456;
    INSTR_VALID <= 1'b1;
    @(negedge MCLK);
    INSTR_VALID <= 1'b0;
    chk({DEST_WRITE, DEST_READ}, {1'b1, 12'h456, 8'h5A, 1'b0});
  endtask : move
  initial begin
    #20000;
    n_fail++;
    test_done;
  end
  initial begin
    RESETN = 1'b0;
    INSTR_VALID = 1'b0;
    INSTR = 16'h0000;
    HIGH_PRIO_MODE = 1'b0;
    STACK_TOP = 21'h1_2345;
    SHADOW = 24'h11_2233;
    CTX_IN = 24'h44_5566;
    SRC_DATA = 8'h5A;
    repeat (16) @(negedge MCLK);
    RESETN <= 1'b1;
    ret_irq(1'b1, 1'b1);
    ret_irq(1'b0, 1'b0);
    ret_lit;
    move;
    test_done;
  end
endmodule : tb

// ===== verilog/rmx_exec.sv
// Execution unit for interrupt return, literal return and file-to-file move.
`timescale 1ns/1ps
module rmx_exec (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [1:0] QPHASE,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic HIGH_PRIO_MODE,
  input wire logic [rmx_pkg::PC_W-1:0] STACK_TOP,
  input wire rmx_pkg::rmx_ctx_t SHADOW,
  input wire rmx_pkg::rmx_ctx_t CTX_IN,
  input wire logic [rmx_pkg::DATA_W-1:0] SRC_DATA,
  output logic STACK_POP,
  output logic PC_LOAD,
  output logic [rmx_pkg::PC_W-1:0] PC_VALUE,
  output logic LATCH_WRITE,
  output logic HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_SET,
  output logic LOW_PRIORITY_GLOBAL_IRQ_ENABLE_SET,
  output logic CTX_LOAD,
  output rmx_pkg::rmx_ctx_t CTX_OUT,
  output logic SRC_READ,
  output logic [rmx_pkg::FADDR_W-1:0] SRC_ADDR,
  output logic DEST_READ,
  output rmx_pkg::rmx_fwr_t DEST_WRITE,
  output logic PIPE_FLUSH,
  output logic BUSY
);
  import rmx_pkg::*;

  function automatic logic op_match(input logic [15:0] op, input logic [15:0] mask, input logic [15:0] base);
    op_match = (op & mask) == base;
  endfunction : op_match

  rmx_state_t state, next_state;
  logic [DATA_W-1:0] move_data, next_move_data;
  logic stack_pop, next_stack_pop;
  logic pc_load, next_pc_load;
  logic [PC_W-1:0] pc_value, next_pc_value;
  logic hi_set, next_hi_set;
  logic lo_set, next_lo_set;
  logic ctx_load, next_ctx_load;
  rmx_ctx_t ctx_out, next_ctx_out;
  logic src_read, next_src_read;
  logic [FADDR_W-1:0] src_addr, next_src_addr;
  rmx_fwr_t dest_write, next_dest_write;
  logic flush, next_flush;
  logic busy, next_busy;
  logic latch_write, next_latch_write;
  logic dest_read, next_dest_read;
  logic decode_slot;

  // Decisions are taken at the first quarter; effects are timed to quarters by QPHASE.
  assign decode_slot = INSTR_VALID && (QPHASE == 2'h0);

  always_comb begin
    next_state = state;
    next_move_data = move_data;
    next_stack_pop = 1'b0;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_hi_set = 1'b0;
    next_lo_set = 1'b0;
    next_ctx_load = 1'b0;
    next_ctx_out = ctx_out;
    next_src_read = 1'b0;
    next_src_addr = src_addr;
    next_dest_write = '{en: 1'b0, addr: dest_write.addr, data: dest_write.data};
    next_flush = 1'b0;
    next_busy = busy;
    next_latch_write = 1'b0;
    next_dest_read = 1'b0;
    case (state)
      RMX_IDLE: begin
        if (decode_slot && op_match(INSTR, RETFI_MASK, RETFI_BASE)) begin
          next_stack_pop = 1'b1;
          next_pc_load = 1'b1;
          next_pc_value = STACK_TOP;
          next_hi_set = HIGH_PRIO_MODE;
          next_lo_set = !HIGH_PRIO_MODE;
          // Without the option the live context is echoed back with no load strobe.
          next_ctx_load = INSTR[OPT_BIT];
          next_ctx_out = INSTR[OPT_BIT] ? SHADOW : CTX_IN;
          next_flush = 1'b1;
          next_busy = 1'b1;
          next_state = RMX_RET2;
        end else if (decode_slot && op_match(INSTR, RETLIT_MASK, RETLIT_BASE)) begin
          next_stack_pop = 1'b1;
          next_pc_load = 1'b1;
          next_pc_value = STACK_TOP;
          next_ctx_load = 1'b1;
          next_ctx_out = '{acc: INSTR[DATA_W-1:0], flags: CTX_IN.flags, bank: CTX_IN.bank};
          next_flush = 1'b1;
          next_busy = 1'b1;
          next_state = RMX_RET2;
        end else if (decode_slot && op_match(INSTR, MOVE_MASK, MOVE_BASE)) begin
          next_src_read = 1'b1;
          next_src_addr = INSTR[FADDR_W-1:0];
          next_busy = 1'b1;
          next_state = RMX_MOVE2;
        end
      end
      RMX_MOVE2: begin
        // Source data is captured once the read strobe has been answered.
        if (QPHASE == 2'h1) begin
          next_move_data = SRC_DATA;
        end
        if (QPHASE == (Q_LAST - 2'h1) && INSTR_VALID && op_match(INSTR, MOVE_MASK, MOVE2_BASE)) begin
          // Destination is only written, never read, so a write-sensitive target sees no access early.
          next_dest_write = '{en: 1'b1, addr: INSTR[FADDR_W-1:0], data: move_data};
          next_busy = 1'b0;
          next_state = RMX_IDLE;
        end
      end
      RMX_RET2: begin
        // The first cycle ends here; releasing now would let a new word in one cycle too early.
        if (QPHASE == Q_LAST) begin
          next_state = RMX_RET_NOP;
        end
      end
      RMX_RET_NOP: begin
        // Second cycle does nothing while the fetch restarts from the new address.
        if (QPHASE == Q_LAST) begin
          next_busy = 1'b0;
          next_state = RMX_IDLE;
        end
      end
      default: begin
        next_state = RMX_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= RMX_IDLE;
      move_data <= '0;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= '0;
      hi_set <= 1'b0;
      lo_set <= 1'b0;
      ctx_load <= 1'b0;
      ctx_out <= '0;
      src_read <= 1'b0;
      src_addr <= '0;
      dest_write <= '0;
      flush <= 1'b0;
      busy <= 1'b0;
      latch_write <= 1'b0;
      dest_read <= 1'b0;
    end else begin
      state <= next_state;
      move_data <= next_move_data;
      stack_pop <= next_stack_pop;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      hi_set <= next_hi_set;
      lo_set <= next_lo_set;
      ctx_load <= next_ctx_load;
      ctx_out <= next_ctx_out;
      src_read <= next_src_read;
      src_addr <= next_src_addr;
      dest_write <= next_dest_write;
      flush <= next_flush;
      busy <= next_busy;
      latch_write <= next_latch_write;
      dest_read <= next_dest_read;
    end
  end

  assign STACK_POP = stack_pop;
  assign PC_LOAD = pc_load;
  assign PC_VALUE = pc_value;
  assign LATCH_WRITE = latch_write;
  assign HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_SET = hi_set;
  assign LOW_PRIORITY_GLOBAL_IRQ_ENABLE_SET = lo_set;
  assign CTX_LOAD = ctx_load;
  assign CTX_OUT = ctx_out;
  assign SRC_READ = src_read;
  assign SRC_ADDR = src_addr;
  assign DEST_READ = dest_read;
  assign DEST_WRITE = dest_write;
  assign PIPE_FLUSH = flush;
  assign BUSY = busy;
endmodule : rmx_exec

// ===== verilog/rmx_pkg.sv
// Package for the return and move execution unit: opcodes, states, carriers.
package rmx_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 21;
  localparam int FADDR_W = 12;
  localparam logic [15:0] RETFI_BASE = 16'h0010;
  localparam logic [15:0] RETFI_MASK = 16'hFFFE;
  localparam logic [15:0] RETLIT_BASE = 16'h0C00;
  localparam logic [15:0] RETLIT_MASK = 16'hFF00;
  localparam logic [15:0] MOVE_BASE = 16'hC000;
  localparam logic [15:0] MOVE_MASK = 16'hF000;
  localparam logic [15:0] MOVE2_BASE = 16'hF000;
  localparam int OPT_BIT = 0;
  localparam logic [1:0] Q_LAST = 2'h3;

  typedef enum logic [1:0] {
    RMX_IDLE = 2'b00,
    RMX_MOVE2 = 2'b01,
    RMX_RET2 = 2'b11,
    RMX_RET_NOP = 2'b10
  } rmx_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] flags;
    logic [DATA_W-1:0] bank;
  } rmx_ctx_t;

  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rmx_fwr_t;
endpackage : rmx_pkg
